/* File: pkg/acc_pkg.sv */
// constants and helpers shared by the calibration control register block
`default_nettype none

package acc_pkg;

    // apb geometry: printed offsets are register indices, byte address is four times the index
    localparam int            APB_AW            = 12;
    localparam int            APB_DW            = 32;
    localparam int            REG_W             = 8;

    // register indices
    localparam logic [9:0]    IDX_CAL_STATUS    = 10'h06a;  // read-only engine status
    localparam logic [9:0]    IDX_PIN_CFG       = 10'h06b;  // trigger source select
    localparam logic [9:0]    IDX_SOFT_TRIG     = 10'h06c;  // software calibration trigger
    localparam logic [9:0]    IDX_LP_CTRL       = 10'h06e;  // low-power calibration control
    localparam logic [9:0]    IDX_DATA_EN       = 10'h070;  // calibration data access enable
    localparam logic [9:0]    IDX_DATA_PORT     = 10'h071;  // calibration data port
    localparam logic [9:0]    IDX_BG_CFG        = 10'h080;  // background calibration enable
    localparam logic [9:0]    IDX_STREAM_CFG    = 10'h081;  // address hold control
    localparam logic [9:0]    IDX_STREAM_STAT   = 10'h082;  // vector transfer progress

    // reset values
    localparam logic [7:0]    RST_LP_CTRL       = 8'h88;
    localparam logic [7:0]    RST_SOFT_TRIG     = 8'h01;
    localparam logic [7:0]    RST_DATA_EN       = 8'h00;
    localparam logic [7:0]    RST_PIN_CFG       = 8'h00;
    localparam logic [7:0]    RST_BG_CFG        = 8'h00;
    localparam logic [7:0]    RST_STREAM_CFG    = 8'h00;

    // field positions
    localparam int            LOW_POWER_CALIBRATION_ENABLE_BIT         = 0;
    localparam int            TRIGGER_WOKEN_MODE_BIT       = 1;
    localparam int            LP_WAKE_LSB       = 3;
    localparam int            LP_SLEEP_LSB      = 5;
    localparam int            SOFT_TRIG_BIT     = 0;
    localparam int            DATA_EN_BIT       = 0;
    localparam int            HW_SEL_BIT        = 0;
    localparam int            BG_EN_BIT         = 1;
    localparam int            ADDR_HOLD_BIT     = 0;
    localparam int            STAT_STOPPED_BIT  = 1;
    localparam int            SS_ACTIVE_BIT     = 0;
    localparam int            SS_DONE_BIT       = 1;
    localparam int            SS_INVALID_BIT    = 2;

    // calibration vector
    localparam int            VEC_IDX_W         = 10;
    localparam logic [9:0]    CAL_VECTOR_LEN    = 10'd673;

    // low-power delays, counted in clock periods: (2^k + 1) * unit
    localparam int            DELAY_UNIT_CYCLES = 256;
    localparam int            DLY_W             = 42;
    localparam int            SLEEP_EXP [8]     = '{3, 15, 18, 21, 24, 27, 30, 33};
    localparam int            WAKE_EXP  [4]     = '{3, 18, 21, 24};

    // one delay in cycles, less one, ready to load into a down counter
    function automatic logic [DLY_W-1:0] acc_delay_load(input int exp, input int unit);
        logic [63:0] full;
        full = ((64'd1 << exp) + 64'd1) * 64'(unit);
        return full[DLY_W-1:0] - 42'd1;
    endfunction : acc_delay_load

endpackage : acc_pkg

`default_nettype wire

/* File: design/acc_lp_sequencer.sv */
// low-power background calibration sequencer: sleep, wake settle, calibrate
`default_nettype none

module acc_lp_sequencer #(
    parameter int UNIT_CYCLES = acc_pkg::DELAY_UNIT_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       lpActive,       // low-power enable and background enable
    input  wire logic       trigWoken,      // trigger-woken mode
    input  wire logic [2:0] sleepCode,      // sleep delay code
    input  wire logic [1:0] wakeCode,       // wake settle delay code
    input  wire logic       calTrigger,     // selected calibration trigger level
    input  wire logic       calRoundDone,   // engine finished one core's calibration
    output logic            adcSleep,       // core held asleep
    output logic            calRoundStart   // one-cycle request to calibrate the woken core
);
    import acc_pkg::*;

    typedef enum logic [1:0] {
        ACC_OFF,
        ACC_CAL,
        ACC_SLEEP,
        ACC_WAKE
    } acc_lp_state_t;

    acc_lp_state_t            state_q, state_d;      // sequencer state
    logic [DLY_W-1:0]         count_q, count_d;      // delay down counter
    logic                     sleep_q, sleep_d;      // registered sleep output
    logic                     start_q, start_d;      // registered start pulse

    // next-state logic; any loss of lpActive drops straight to off
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        sleep_d = 1'b0;
        start_d = 1'b0;
        case (state_q)
            ACC_OFF: begin
                if (lpActive) begin
                    state_d = ACC_CAL;
                end
            end
            ACC_CAL: begin
                // sleep delay is sampled on entry, so a code change applies to the next sleep
                if (calRoundDone) begin
                    state_d = ACC_SLEEP;
                    count_d = acc_delay_load(SLEEP_EXP[sleepCode], UNIT_CYCLES);
                    sleep_d = 1'b1;
                end
            end
            ACC_SLEEP: begin
                sleep_d = 1'b1;
                if (trigWoken) begin
                    // sleep indefinitely until the trigger goes low
                    if (!calTrigger) begin
                        state_d = ACC_WAKE;
                        count_d = acc_delay_load(WAKE_EXP[wakeCode], UNIT_CYCLES);
                        sleep_d = 1'b0;
                    end
                end else if (count_q == '0) begin
                    state_d = ACC_WAKE;
                    count_d = acc_delay_load(WAKE_EXP[wakeCode], UNIT_CYCLES);
                    sleep_d = 1'b0;
                end else begin
                    count_d = count_q - 42'd1;
                end
            end
            ACC_WAKE: begin
                // settle before calibrating the freshly woken core
                if (count_q == '0) begin
                    state_d = ACC_CAL;
                    start_d = 1'b1;
                end else begin
                    count_d = count_q - 42'd1;
                end
            end
            default: begin
                state_d = ACC_OFF;
            end
        endcase
        if (!lpActive) begin
            state_d = ACC_OFF;
            sleep_d = 1'b0;
            start_d = 1'b0;
        end
    end

    // sequencer registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ACC_OFF;
            count_q <= '0;
            sleep_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            sleep_q <= sleep_d;
            start_q <= start_d;
        end
    end

    assign adcSleep      = sleep_q;
    assign calRoundStart = start_q;

endmodule : acc_lp_sequencer

`default_nettype wire

/* File: design/acc_regs.sv */
// calibration control register bank on apb with low-power sequencer and data port
//
// Local design decision: register access over APB.
`default_nettype none

module acc_regs #(
    parameter int UNIT_CYCLES = acc_pkg::DELAY_UNIT_CYCLES  // shorten in simulation
) (
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [acc_pkg::APB_AW-1:0]  paddr,
    input  wire logic [acc_pkg::APB_DW-1:0]  pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [acc_pkg::APB_DW-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    // trigger pin and engine status
    input  wire logic                        hwCalibrationTriggerInput,
    input  wire logic                        calStopped,
    input  wire logic                        calRoundDone,
    // calibration vector port towards the cores
    input  wire logic [7:0]                  calVecRdata,
    output logic      [acc_pkg::VEC_IDX_W-1:0] calVecIndex,
    output logic                             calVecRead,
    output logic                             calVecWrite,
    output logic      [7:0]                  calVecWdata,
    // towards the calibration engine
    output logic                             calibrationTrigger,
    output logic                             backgroundCalibrationEnable,
    output logic                             lowPowerActive,
    output logic                             adcSleep,
    output logic                             calRoundStart
);
    import acc_pkg::*;

    // true when the word address selects the given register index
    function automatic logic acc_hit(input logic [9:0] wordAddr, input logic [9:0] idx);
        return wordAddr == idx;
    endfunction : acc_hit

    logic [7:0]           lpCtrl_q, lpCtrl_d;        // low_power_calibration_control
    logic [7:0]           softTrig_q, softTrig_d;    // software_calibration_trigger
    logic [7:0]           dataEn_q, dataEn_d;        // calibration_data_access_enable
    logic [7:0]           pinCfg_q, pinCfg_d;        // trigger source configuration
    logic [7:0]           bgCfg_q, bgCfg_d;          // background calibration config
    logic [7:0]           streamCfg_q, streamCfg_d;  // address hold config
    logic [VEC_IDX_W-1:0] vecIdx_q, vecIdx_d;        // position in the calibration vector
    logic                 seqActive_q, seqActive_d;  // a transfer has started
    logic                 seqDone_q, seqDone_d;      // full vector moved
    logic                 seqInvalid_q, seqInvalid_d; // transfer abandoned part way
    logic                 vecRead_q, vecRead_d;      // registered read strobe
    logic                 vecWrite_q, vecWrite_d;    // registered write strobe
    logic [7:0]           vecWdata_q, vecWdata_d;    // registered write data
    logic [31:0]          prdata_q, prdata_d;        // read data captured in setup phase
    logic                 pslverr_q, pslverr_d;      // error captured in setup phase
    logic                 trigMeta_q, trigSync_q;    // pin synchroniser pair

    logic [9:0]           wordAddr;                  // paddr as register index
    logic [9:0]           effIdx;                    // index after address hold
    logic                 setupPhase;                // apb setup cycle
    logic                 accessDone;                // apb access completes this edge
    logic                 portOpen;                  // data port enabled
    logic                 mapped;                    // address decodes to a register
    logic                 sleepWanted;               // sequencer asks for sleep

    assign wordAddr   = paddr[11:2];
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable;
    assign portOpen   = dataEn_q[DATA_EN_BIT];

    // with address hold set every access except to the hold control lands on the data port
    always_comb begin
        effIdx = wordAddr;
        if (streamCfg_q[ADDR_HOLD_BIT] && !acc_hit(wordAddr, IDX_STREAM_CFG)) begin
            effIdx = IDX_DATA_PORT;
        end
    end

    // decode for the error answer; unmapped words answer with pslverr
    always_comb begin
        mapped = acc_hit(effIdx, IDX_CAL_STATUS) || acc_hit(effIdx, IDX_PIN_CFG)
            || acc_hit(effIdx, IDX_SOFT_TRIG) || acc_hit(effIdx, IDX_LP_CTRL)
            || acc_hit(effIdx, IDX_DATA_EN) || acc_hit(effIdx, IDX_DATA_PORT)
            || acc_hit(effIdx, IDX_BG_CFG) || acc_hit(effIdx, IDX_STREAM_CFG)
            || acc_hit(effIdx, IDX_STREAM_STAT);
    end

    // read data and error are registered in the setup cycle; index is stable until completion
    always_comb begin
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        if (setupPhase) begin
            prdata_d  = '0;
            pslverr_d = !mapped;
            if (!pwrite) begin
                case (1'b1)
                    acc_hit(effIdx, IDX_CAL_STATUS): begin
                        prdata_d[STAT_STOPPED_BIT] = calStopped;
                    end
                    acc_hit(effIdx, IDX_PIN_CFG):    prdata_d[7:0] = pinCfg_q;
                    acc_hit(effIdx, IDX_SOFT_TRIG):  prdata_d[7:0] = softTrig_q;
                    acc_hit(effIdx, IDX_LP_CTRL):    prdata_d[7:0] = lpCtrl_q;
                    acc_hit(effIdx, IDX_DATA_EN):    prdata_d[7:0] = dataEn_q;
                    acc_hit(effIdx, IDX_DATA_PORT): begin
                        // a closed port reads zero and leaves the vector alone
                        if (portOpen) begin
                            prdata_d[7:0] = calVecRdata;
                        end
                    end
                    acc_hit(effIdx, IDX_BG_CFG):     prdata_d[7:0] = bgCfg_q;
                    acc_hit(effIdx, IDX_STREAM_CFG): prdata_d[7:0] = streamCfg_q;
                    acc_hit(effIdx, IDX_STREAM_STAT): begin
                        prdata_d[SS_ACTIVE_BIT]  = seqActive_q;
                        prdata_d[SS_DONE_BIT]    = seqDone_q;
                        prdata_d[SS_INVALID_BIT] = seqInvalid_q;
                    end
                    default: prdata_d = '0;
                endcase
            end
        end
    end

    // control register writes; only byte lane zero carries register bits
    always_comb begin
        lpCtrl_d    = lpCtrl_q;
        softTrig_d  = softTrig_q;
        dataEn_d    = dataEn_q;
        pinCfg_d    = pinCfg_q;
        bgCfg_d     = bgCfg_q;
        streamCfg_d = streamCfg_q;
        if (accessDone && pwrite && pstrb[0]) begin
            case (1'b1)
                acc_hit(effIdx, IDX_LP_CTRL):    lpCtrl_d    = pwdata[7:0];
                acc_hit(effIdx, IDX_SOFT_TRIG):  softTrig_d  = pwdata[7:0];
                acc_hit(effIdx, IDX_DATA_EN):    dataEn_d    = pwdata[7:0];
                acc_hit(effIdx, IDX_PIN_CFG):    pinCfg_d    = pwdata[7:0];
                acc_hit(effIdx, IDX_BG_CFG):     bgCfg_d     = pwdata[7:0];
                acc_hit(effIdx, IDX_STREAM_CFG): streamCfg_d = pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // vector walk: each completed access to the open port moves one value and steps the index
    always_comb begin
        vecIdx_d     = vecIdx_q;
        seqActive_d  = seqActive_q;
        seqDone_d    = seqDone_q;
        seqInvalid_d = seqInvalid_q;
        vecRead_d    = 1'b0;
        vecWrite_d   = 1'b0;
        vecWdata_d   = vecWdata_q;
        // opening the port starts a fresh walk from the first value
        if (dataEn_d[DATA_EN_BIT] && !portOpen) begin
            vecIdx_d     = '0;
            seqActive_d  = 1'b0;
            seqDone_d    = 1'b0;
            seqInvalid_d = 1'b0;
        end
        // closing mid-walk marks the stored calibration unusable
        if (!dataEn_d[DATA_EN_BIT] && portOpen && seqActive_q) begin
            seqInvalid_d = 1'b1;
            seqActive_d  = 1'b0;
        end
        if (accessDone && portOpen && acc_hit(effIdx, IDX_DATA_PORT)) begin
            if (pwrite) begin
                // a write without lane zero still counts, so the walk stays aligned
                vecWrite_d = 1'b1;
                vecWdata_d = pstrb[0] ? pwdata[7:0] : 8'h00;
            end else begin
                vecRead_d = 1'b1;
            end
            if (vecIdx_q == CAL_VECTOR_LEN - 10'd1) begin
                vecIdx_d    = '0;
                seqActive_d = 1'b0;
                seqDone_d   = 1'b1;
            end else begin
                vecIdx_d    = vecIdx_q + 10'd1;
                seqActive_d = 1'b1;
                seqDone_d   = 1'b0;
            end
        end
    end

    // all register state; the pin passes two flops before any use
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lpCtrl_q     <= RST_LP_CTRL;
            softTrig_q   <= RST_SOFT_TRIG;
            dataEn_q     <= RST_DATA_EN;
            pinCfg_q     <= RST_PIN_CFG;
            bgCfg_q      <= RST_BG_CFG;
            streamCfg_q  <= RST_STREAM_CFG;
            vecIdx_q     <= '0;
            seqActive_q  <= 1'b0;
            seqDone_q    <= 1'b0;
            seqInvalid_q <= 1'b0;
            vecRead_q    <= 1'b0;
            vecWrite_q   <= 1'b0;
            vecWdata_q   <= 8'h00;
            prdata_q     <= '0;
            pslverr_q    <= 1'b0;
            trigMeta_q   <= 1'b0;
            trigSync_q   <= 1'b0;
        end else begin
            lpCtrl_q     <= lpCtrl_d;
            softTrig_q   <= softTrig_d;
            dataEn_q     <= dataEn_d;
            pinCfg_q     <= pinCfg_d;
            bgCfg_q      <= bgCfg_d;
            streamCfg_q  <= streamCfg_d;
            vecIdx_q     <= vecIdx_d;
            seqActive_q  <= seqActive_d;
            seqDone_q    <= seqDone_d;
            seqInvalid_q <= seqInvalid_d;
            vecRead_q    <= vecRead_d;
            vecWrite_q   <= vecWrite_d;
            vecWdata_q   <= vecWdata_d;
            prdata_q     <= prdata_d;
            pslverr_q    <= pslverr_d;
            trigMeta_q   <= hwCalibrationTriggerInput;
            trigSync_q   <= trigMeta_q;
        end
    end

    // trigger source select; the unused source is ignored outright
    always_comb begin
        if (pinCfg_q[HW_SEL_BIT]) begin
            calibrationTrigger = trigSync_q;
        end else begin
            calibrationTrigger = softTrig_q[SOFT_TRIG_BIT];
        end
    end

    // low power only runs on top of background calibration
    assign backgroundCalibrationEnable = bgCfg_q[BG_EN_BIT];
    assign lowPowerActive = lpCtrl_q[LOW_POWER_CALIBRATION_ENABLE_BIT] && bgCfg_q[BG_EN_BIT];

    acc_lp_sequencer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_lp_sequencer (
        .clk_sys       (clk_sys),
        .reset_n       (reset_n),
        .lpActive      (lowPowerActive),
        .trigWoken     (lpCtrl_q[TRIGGER_WOKEN_MODE_BIT]),
        .sleepCode     (lpCtrl_q[LP_SLEEP_LSB +: 3]),
        .wakeCode      (lpCtrl_q[LP_WAKE_LSB +: 2]),
        .calTrigger    (calibrationTrigger),
        .calRoundDone  (calRoundDone),
        .adcSleep      (sleepWanted),
        .calRoundStart (calRoundStart)
    );

    assign adcSleep    = sleepWanted;
    assign calVecIndex = vecIdx_q;
    assign calVecRead  = vecRead_q;
    assign calVecWrite = vecWrite_q;
    assign calVecWdata = vecWdata_q;

    // zero-wait slave: the access phase always completes in its first cycle
    assign pready  = psel && penable;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q && psel && penable;

endmodule : acc_regs

`default_nettype wire

/* File: tb/acc_regs_assertions.sv */
// concurrent checks on the calibration control register bank ports
`default_nettype none

module acc_regs_checker (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic calVecRead,
    input wire logic calVecWrite,
    input wire logic backgroundCalibrationEnable,
    input wire logic lowPowerActive,
    input wire logic adcSleep,
    input wire logic calRoundStart
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // vector read strobe and round start are single-cycle pulses
    sequence s_read_once;
        calVecRead ##1 !calVecRead;
    endsequence
    sequence s_start_once;
        calRoundStart ##1 !calRoundStart;
    endsequence

    a_ready_zero_wait: assert property (psel && penable |-> pready)
        else $error("access cycle without ready");
    a_read_cause: assert property (calVecRead |-> $past(psel && penable && !pwrite))
        else $error("vector read without a completed read");
    a_read_single: assert property (calVecRead |-> s_read_once)
        else $error("vector read pulse too long");
    a_write_cause: assert property (calVecWrite |-> $past(psel && penable && pwrite))
        else $error("vector write without a completed write");
    a_vec_exclusive: assert property (!(calVecRead && calVecWrite))
        else $error("vector read and write together");
    a_lp_needs_bg: assert property (lowPowerActive |-> backgroundCalibrationEnable)
        else $error("low power active without background enable");
    a_sleep_gated: assert property (!lowPowerActive |=> !adcSleep)
        else $error("core asleep while low power is off");
    a_start_awake: assert property (calRoundStart |-> !adcSleep)
        else $error("round started on a sleeping core");
    a_start_single: assert property (calRoundStart |-> s_start_once)
        else $error("round start pulse too long");
endmodule : acc_regs_checker

bind acc_regs acc_regs_checker u_acc_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .calVecRead(calVecRead), .calVecWrite(calVecWrite),
    .backgroundCalibrationEnable(backgroundCalibrationEnable),
    .lowPowerActive(lowPowerActive), .adcSleep(adcSleep), .calRoundStart(calRoundStart)
);

`default_nettype wire

/* File: tb/acc_engine_model.sv */
// behavioural calibration engine and core vector store behind the bank
`default_nettype none

module acc_engine_model #(
    parameter int DONE_LAG = 3  // cycles one core calibration takes
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       lpActive,
    input  wire logic [9:0] calVecIndex,
    input  wire logic       calVecWrite,
    input  wire logic [7:0] calVecWdata,
    input  wire logic       calRoundStart,
    output logic      [7:0] calVecRdata,
    output logic            calRoundDone,
    output logic            calStopped
);
    logic [7:0] vecMem [673];  // stored vector, seeded with a known pattern
    int         busyCnt;       // cycles left in the current round
    logic       lpPrev;        // last low-power level, to see it rise
    initial for (int i = 0; i < 673; i++) vecMem[i] = 8'(i * 7 + 3);
    assign calVecRdata = vecMem[calVecIndex];
    assign calStopped  = (busyCnt == 0);
    // a round runs on each start and on entry to low power
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busyCnt <= 0;
            lpPrev <= 1'b0;
            calRoundDone <= 1'b0;
        end else begin
            lpPrev <= lpActive;
            calRoundDone <= (busyCnt == 1);
            if (calRoundStart || (lpActive && !lpPrev)) busyCnt <= DONE_LAG;
            else if (busyCnt != 0) busyCnt <= busyCnt - 1;
            // index has already stepped past the value
            if (calVecWrite) vecMem[calVecIndex == 0 ? 672 : calVecIndex - 1] <= calVecWdata;
        end
    end
endmodule : acc_engine_model

`default_nettype wire

/* File: tb/tb_acc_regs.sv */
// self-checking bench for the calibration control register bank
`default_nettype none

module tb_acc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import acc_pkg::*;
    logic        clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, hwTrig = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, errFlag, calStopped, calRoundDone, calVecRead, calVecWrite;
    logic        hw_calibration_trigger_input, bgEn, lpAct, adcSleep, calRoundStart;
    logic [7:0]  calVecRdata, calVecWdata, rd;
    logic [9:0]  calVecIndex;
    int          n_errors = 0, samples_checked = 0;

    initial forever #2.5 clk_sys = ~clk_sys;

    acc_regs #(.UNIT_CYCLES(1)) u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hwCalibrationTriggerInput(hwTrig), .calStopped(calStopped),
        .calRoundDone(calRoundDone), .calVecRdata(calVecRdata), .calVecIndex(calVecIndex),
        .calVecRead(calVecRead), .calVecWrite(calVecWrite), .calVecWdata(calVecWdata),
        .calibrationTrigger(hw_calibration_trigger_input), .backgroundCalibrationEnable(bgEn),
        .lowPowerActive(lpAct), .adcSleep(adcSleep), .calRoundStart(calRoundStart)
    );
    acc_engine_model u_engine (
        .clk_sys(clk_sys), .reset_n(reset_n), .lpActive(lpAct), .calVecIndex(calVecIndex),
        .calVecWrite(calVecWrite), .calVecWdata(calVecWdata), .calRoundStart(calRoundStart),
        .calVecRdata(calVecRdata), .calRoundDone(calRoundDone), .calStopped(calStopped)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask : cyc
    // one transfer, held until pready is sampled high, then an idle edge
    task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata[7:0];
        errFlag = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
        apb(idx, 1'b0, 8'h00);
        chk(rd, exp);
    endtask : rdchk
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // watchdog: the run needs about 6200 cycles
    initial begin
        cyc(30000);
        n_errors++;
        complete_run();
    end

    initial begin
        int cnt;
        cyc(6);
        reset_n <= 1'b1;
        cyc(1);
        rdchk(IDX_LP_CTRL, 8'h88);
        rdchk(IDX_SOFT_TRIG, 8'h01);
        rdchk(IDX_DATA_EN, 8'h00);
        chk(hw_calibration_trigger_input, 1'b1);
        apb(10'h0ff, 1'b0, 8'h00);
        chk(errFlag, 1'b1);
        apb(IDX_CAL_STATUS, 1'b0, 8'h00);
        chk(rd[STAT_STOPPED_BIT], 1'b1);
        $display("test resets done");
        // pin level differs from the software bit so each source shows
        apb(IDX_SOFT_TRIG, 1'b1, 8'h00);
        chk(hw_calibration_trigger_input, 1'b0);
        apb(IDX_PIN_CFG, 1'b1, 8'h01);
        hwTrig <= 1'b1;
        cyc(4);
        chk(hw_calibration_trigger_input, 1'b1);
        apb(IDX_PIN_CFG, 1'b1, 8'h00);
        chk(hw_calibration_trigger_input, 1'b0);
        apb(IDX_SOFT_TRIG, 1'b1, 8'h01);
        $display("test trigger source done");
        rdchk(IDX_DATA_PORT, 8'h00);
        chk(calVecIndex, 10'd0);
        apb(IDX_DATA_EN, 1'b1, 8'h01);
        for (int i = 0; i < 673; i++) rdchk(IDX_DATA_PORT, 8'(i * 7 + 3));
        for (int i = 0; i < 673; i++) apb(IDX_DATA_PORT, 1'b1, 8'(i ^ 8'h5a));
        for (int i = 0; i < 673; i++) rdchk(IDX_DATA_PORT, 8'(i ^ 8'h5a));
        apb(IDX_DATA_EN, 1'b1, 8'h00);
        $display("test vector port done");
        // streaming aimed at another index, then abandoned early
        apb(IDX_DATA_EN, 1'b1, 8'h01);
        apb(IDX_STREAM_CFG, 1'b1, 8'h01);
        for (int i = 0; i < 3; i++) rdchk(IDX_LP_CTRL, 8'(i ^ 8'h5a));
        apb(IDX_STREAM_CFG, 1'b1, 8'h00);
        apb(IDX_DATA_EN, 1'b1, 8'h00);
        apb(IDX_STREAM_STAT, 1'b0, 8'h00);
        chk(rd & 8'h04, 8'h04);
        $display("test streaming done");
        // autonomous low power with the shortest codes, reserved bit left zero
        apb(IDX_LP_CTRL, 1'b1, 8'h01);
        chk(lpAct, 1'b0);
        apb(IDX_BG_CFG, 1'b1, 8'h02);
        chk({bgEn, lpAct}, 2'b11);
        while (adcSleep !== 1'b1) cyc(1);
        for (cnt = 0; adcSleep === 1'b1; cnt++) cyc(1);
        chk(cnt, 9);
        for (cnt = 0; calRoundStart !== 1'b1; cnt++) cyc(1);
        chk(cnt, 9);
        apb(IDX_LP_CTRL, 1'b1, 8'h8b);
        cyc(40);
        chk(adcSleep, 1'b1);
        apb(IDX_SOFT_TRIG, 1'b1, 8'h00);
        cyc(2);
        chk(adcSleep, 1'b0);
        apb(IDX_SOFT_TRIG, 1'b1, 8'h01);
        apb(IDX_LP_CTRL, 1'b1, 8'h00);
        chk(lpAct, 1'b0);
        $display("test low power done");
        complete_run();
    end
endmodule : tb_acc_regs

`default_nettype wire
